// ### common/pa_pkg.sv
// Constants shared by the six-bit port A pin logic.
// Assumes a byte-wide register port with a four-bit word address.
package pa_pkg;

    // Bus and port widths.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int PORT_W = 6;

    // Register addresses on the plain register port.
    localparam logic [ADDR_W-1:0] OFS_PIN_READ  = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_LATCH     = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_DIRECTION = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_SHARED    = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_WDT_CTRL  = 4'h4;

    // Implemented-bit masks; every other bit reads as zero.
    localparam logic [DATA_W-1:0] PORT_IMPL_MASK = 8'h3f;
    localparam logic [DATA_W-1:0] ANSEL_IMPL_MASK = 8'h9f;
    localparam logic [DATA_W-1:0] ALT_IMPL_MASK = 8'h0f;
    localparam logic [DATA_W-1:0] WDT_IMPL_MASK = 8'h10;

    // Reset values.
    localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;
    localparam logic [DATA_W-1:0] DIR_RST   = 8'h3f;
    localparam logic [DATA_W-1:0] ANSEL_RST = 8'h00;
    localparam logic [DATA_W-1:0] ALT_RST   = 8'h00;
    localparam logic [DATA_W-1:0] WDT_RST   = 8'h00;

    // Field positions.
    localparam int ACCESS_BIT     = 4;
    localparam int ALT_COMPARATOR_REFERENCE_OUTPUT_BIT  = 0;
    localparam int ALT_PMP_BIT    = 1;
    localparam int ALT_TMR_BIT    = 2;
    localparam int ALT_SPARE_BIT  = 3;
    localparam int COMPARATOR_REFERENCE_OUTPUT_PIN      = 2;
    localparam int TIMER_PIN      = 4;
    localparam int PMP_LINE5_PIN  = 4;
    localparam int PMP_LINE4_PIN  = 5;
    localparam int DIGITAL_PIN    = 4;
    localparam int CH4_PIN        = 5;
    localparam int CH4_CFG_BIT    = 4;

endpackage

// ### design/pa_sync.sv
// Three-stage input synchroniser with a two-stage agreement filter.
// Assumes the inputs come from pins outside the clock domain.
`timescale 1ns/1ps
module pa_sync #(
    parameter int W = 6
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] level_o
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;

    // The first stage feeds only the second, so metastability stays contained.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit changes only once stages two and three agree.
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge ref_clk_i) begin
                if (!rst_n_i) begin
                    level_q[g] <= 1'b0;
                end else if (s2_q[g] == s3_q[g]) begin
                    level_q[g] <= s3_q[g];
                end
            end
        end
    endgenerate

    assign level_o = level_q;

endmodule

// ### design/pa_pin_mux.sv
// Per-pin direction and data selection for one port pin.
// Assumes all inputs are on the core clock; the result is registered by the caller.
`timescale 1ns/1ps
module pa_pin_mux (
    input  wire logic latch_i,
    input  wire logic dir_i,
    input  wire logic analog_i,
    input  wire logic block_i,
    input  wire logic force_in_i,
    input  wire logic alt_drive_i,
    input  wire logic alt_data_i,
    input  wire logic pin_level_i,
    output logic      out_o,
    output logic      oe_o,
    output logic      read_o
);

    // Priority: reference output, peripheral drive, forced input, port direction.
    always_comb begin
        out_o = latch_i;
        oe_o  = 1'b0;
        if (block_i) begin
            out_o = 1'b0;
            oe_o  = 1'b0;
        end else if (alt_drive_i) begin
            out_o = alt_data_i;
            oe_o  = 1'b1;
        end else if (force_in_i) begin
            oe_o  = 1'b0;
        end else begin
            oe_o  = ~dir_i;
        end
    end

    // Analog selection does not touch the output path, only the input path.
    assign read_o = pin_level_i & ~analog_i & ~block_i;

endmodule

// ### design/pa_port_top.sv
// Six-bit port A pin logic: output latch, direction, pin read and analog select.
// Assumes a single-master register port and pins resolved outside from out/oe.
// Register map on the word-addressed port, one byte per address:
//   Address 0 is the pin-read register; a write to it lands in the output latch.
//   Address 1 is the output latch and address 2 the direction register, 1 = input.
//   Address 3 holds the analog select while the access bit is set.
//   With the access bit clear, address 3 holds the alternate-function enables.
//   Address 4 is the watchdog control word; only its access bit lives here.
// Alternate enables: bit 0 puts the comparator reference on pin 2, bit 1 turns on
// the parallel port, bit 2 the timer clock input, and bit 3 is a spare.
// Analog select: bits 3 to 0 serve pins 3 to 0 and bit 4 serves pin 5.
// Bit 7 of the analog select is stored only; a set bit means digital.
//
// Timing: a write lands at its strobe edge and reaches the pads one edge later.
// A read answers in the next cycle only, and rdata_o is zero in every other cycle.
// A pin change needs about five edges to reach the pin-read register.
//
// Limitations: the two oscillator pins, the pull-ups and the input buffer
// thresholds are outside this block; analog levels never pass through it,
// only the per-pin mode is reported on analog_sel_o.
`timescale 1ns/1ps
module pa_port_top (
    // Core clock and synchronous reset.
    input  wire logic                         ref_clk_i,
    input  wire logic                         rst_n_i,
    // Register port: one strobe per access, read data one cycle later.
    input  wire logic [pa_pkg::ADDR_W-1:0]    addr_i,
    input  wire logic [pa_pkg::DATA_W-1:0]    wdata_i,
    input  wire logic                         wr_i,
    input  wire logic                         rd_i,
    output logic      [pa_pkg::DATA_W-1:0]    rdata_o,
    // Pad side: raw levels in, registered drive value and drive enable out.
    input  wire logic [pa_pkg::PORT_W-1:0]    pin_in_i,
    output logic      [pa_pkg::PORT_W-1:0]    pin_out_o,
    output logic      [pa_pkg::PORT_W-1:0]    pin_oe_o,
    output logic      [pa_pkg::PORT_W-1:0]    analog_sel_o,
    // Straps and peripheral hookups, all on the core clock.
    input  wire logic                         parallel_port_pin_placement_i,
    input  wire logic                         large_package_i,
    input  wire logic [1:0]                   pmp_data_out_i,
    input  wire logic                         pmp_data_oe_i,
    output logic      [1:0]                   pmp_data_in_o,
    output logic                              timer0_clock_o,
    output logic                              comparator_reference_output_active_o
);
    import pa_pkg::*;

    // Software-visible state. Each register is a full byte so that the read
    // path can mask every one the same way; bits that are never written stay
    // at their reset value and cost nothing once synthesised.
    logic [DATA_W-1:0] latch_q;
    logic [DATA_W-1:0] dir_q;
    logic [DATA_W-1:0] ansel_q;
    logic [DATA_W-1:0] alt_q;
    logic [DATA_W-1:0] wdt_q;
    logic [DATA_W-1:0] rdata_q;

    // Pin-facing state. The selector outputs are combinational per pin, and
    // everything that leaves the block comes from a flop so the pads see no
    // glitches from the priority logic.
    logic [PORT_W-1:0] pin_level;
    logic [PORT_W-1:0] mux_out;
    logic [PORT_W-1:0] mux_oe;
    logic [PORT_W-1:0] mux_read;
    logic [PORT_W-1:0] analog;
    logic [PORT_W-1:0] block;
    logic [PORT_W-1:0] force_in;
    logic [PORT_W-1:0] alt_drive;
    logic [PORT_W-1:0] alt_data;
    logic [PORT_W-1:0] pin_out_q;
    logic [PORT_W-1:0] pin_oe_q;
    logic [PORT_W-1:0] read_q;
    logic [1:0]        pmp_in_q;
    logic              timer_q;

    // Decoded control terms. They are recomputed every cycle from the stored
    // registers and the strobes, so they hold no state of their own.
    logic access_en;
    logic pmp_active;
    logic comparator_reference_output_en;
    logic timer_en;
    logic wr_latch;
    logic wr_dir;
    logic wr_ansel;
    logic wr_alt;
    logic wr_wdt;

    // Write decode; the shared address goes to one of two registers.
    // The access bit is taken from the stored register, so a write that flips
    // it steers shared-address accesses only from the next cycle on.
    always_comb begin
        access_en = wdt_q[ACCESS_BIT];
        wr_latch  = wr_i && ((addr_i == OFS_LATCH) ||
                             (addr_i == OFS_PIN_READ));
        wr_dir    = wr_i && (addr_i == OFS_DIRECTION);
        wr_ansel  = wr_i && (addr_i == OFS_SHARED) && access_en;
        wr_alt    = wr_i && (addr_i == OFS_SHARED) && !access_en;
        wr_wdt    = wr_i && (addr_i == OFS_WDT_CTRL);
    end

    // Output latch; only the six port bits are stored.
    // Writes to either the latch or the pin-read address land here, so
    // software may clear the outputs through whichever name it prefers.
    // Bits 7 and 6 of the write data are dropped.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            latch_q <= LATCH_RST;
        end else if (wr_latch) begin
            latch_q <= wdata_i & PORT_IMPL_MASK;
        end
    end

    // Direction register; pins come up as inputs.
    // Coming up as inputs keeps the pads quiet until software has loaded
    // the latch, so no pin ever drives a stale level after reset.
    // Only bits 5 to 0 exist; bits 7 and 6 always read as zero.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            dir_q <= DIR_RST;
        end else if (wr_dir) begin
            dir_q <= wdata_i & PORT_IMPL_MASK;
        end
    end

    // Analog-select register; clear bits mean analog, so reset leaves all channels analog.
    // Writes are dropped here while the access bit is clear; the alternate
    // register behind the same address takes them instead.
    // Bit 7 is stored and read back but steers no pin in this block.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ansel_q <= ANSEL_RST;
        end else if (wr_ansel) begin
            ansel_q <= wdata_i & ANSEL_IMPL_MASK;
        end
    end

    // Ordinary register behind the shared address: alternate-function enables.
    // Bit 3 is a spare that stores and reads back but has no effect; keeping
    // it writable lets software use one read-modify-write sequence for all.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            alt_q <= ALT_RST;
        end else if (wr_alt) begin
            alt_q <= wdata_i & ALT_IMPL_MASK;
        end
    end

    // Watchdog control register; only the shared-space access bit lives here.
    // The rest of the watchdog control word belongs to other blocks, so its
    // bits read as zero here and a write to them is simply dropped.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wdt_q <= WDT_RST;
        end else if (wr_wdt) begin
            wdt_q <= wdata_i & WDT_IMPL_MASK;
        end
    end

    // Read data is registered so it stands exactly in the cycle after the strobe.
    // Forcing zero outside the answer cycle lets several slaves share one
    // OR-combined read bus without any further gating.
    // Unmapped addresses answer zero.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
        end else if (rd_i) begin
            case (addr_i)
                OFS_PIN_READ: begin
                    rdata_q <= {2'h0, read_q};
                end
                OFS_LATCH: begin
                    rdata_q <= latch_q & PORT_IMPL_MASK;
                end
                OFS_DIRECTION: begin
                    rdata_q <= dir_q & PORT_IMPL_MASK;
                end
                OFS_SHARED: begin
                    if (access_en) begin
                        rdata_q <= ansel_q & ANSEL_IMPL_MASK;
                    end else begin
                        rdata_q <= alt_q & ALT_IMPL_MASK;
                    end
                end
                OFS_WDT_CTRL: begin
                    rdata_q <= wdt_q & WDT_IMPL_MASK;
                end
                default: begin
                    rdata_q <= '0;
                end
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign rdata_o = rdata_q;

    // Pin levels cross into the clock domain before anything looks at them.
    // The filter adds a cycle on top of the three stages, so software that
    // polls a pin must allow some five edges before a change shows.
    // Reset clears the filter, so every pin reads low until it has settled.
    pa_sync #(
        .W (PORT_W)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (pin_in_i),
        .level_o   (pin_level)
    );

    // Parallel data needs the placement strap clear and the large package strap set.
    // The straps are static in use, so they are taken without synchronising;
    // changing one on the fly gives a cycle in which pin ownership is mixed.
    // The comparator and timer enables come straight from the alternate register.
    always_comb begin
        pmp_active = alt_q[ALT_PMP_BIT] && !parallel_port_pin_placement_i &&
                     large_package_i;
        comparator_reference_output_en   = alt_q[ALT_COMPARATOR_REFERENCE_OUTPUT_BIT];
        timer_en   = alt_q[ALT_TMR_BIT];
    end

    // Analog mapping: channels 0 to 3 on bits 0 to 3, channel 4 on bit 5, bit 4 digital.
    // Bit 4 has no converter channel and can never be analog, so after reset
    // it is the only pin whose digital input path is open.
    // A set configuration bit means digital, so the inverse gives the analog mask.
    always_comb begin
        analog              = '0;
        analog[3:0]         = ~ansel_q[3:0];
        analog[DIGITAL_PIN] = 1'b0;
        analog[CH4_PIN]     = ~ansel_q[CH4_CFG_BIT];
    end

    // Per-pin overrides from the comparator reference, timer and parallel port.
    // Only bits 2, 4 and 5 have alternate functions; the other pins keep all
    // four override terms at zero and behave as plain port pins.
    always_comb begin
        block                = '0;
        force_in             = '0;
        alt_drive            = '0;
        alt_data             = '0;
        // Bit 2: the comparator reference takes the pad away from the port.
        block[COMPARATOR_REFERENCE_OUTPUT_PIN]     = comparator_reference_output_en;
        // Bits 4 and 5: timer and parallel inputs leave the direction bit out.
        force_in[TIMER_PIN]  = timer_en || pmp_active;
        force_in[PMP_LINE4_PIN] = pmp_active;
        // The parallel port drives both data lines whenever it asks to.
        alt_drive[PMP_LINE5_PIN] = pmp_active && pmp_data_oe_i;
        alt_drive[PMP_LINE4_PIN] = pmp_active && pmp_data_oe_i;
        alt_data[PMP_LINE5_PIN]  = pmp_data_out_i[1];
        alt_data[PMP_LINE4_PIN]  = pmp_data_out_i[0];
    end

    // One pin selector per bit.
    // Keeping the selector per pin means every pin resolves its priority the
    // same way, and a new alternate function touches only the override terms.
    genvar g;
    generate
        for (g = 0; g < PORT_W; g++) begin : g_pin
            pa_pin_mux u_mux (
                .latch_i     (latch_q[g]),
                .dir_i       (dir_q[g]),
                .analog_i    (analog[g]),
                .block_i     (block[g]),
                .force_in_i  (force_in[g]),
                .alt_drive_i (alt_drive[g]),
                .alt_data_i  (alt_data[g]),
                .pin_level_i (pin_level[g]),
                .out_o       (mux_out[g]),
                .oe_o        (mux_oe[g]),
                .read_o      (mux_read[g])
            );
        end
    endgenerate

    // Pin drivers are registered; reset leaves every pin undriven.
    // The register costs one cycle of latency but keeps the pads clear of
    // glitches while the priority terms settle.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pin_out_q <= '0;
            pin_oe_q  <= '0;
        end else begin
            pin_out_q <= mux_out;
            pin_oe_q  <= mux_oe;
        end
    end

    // Pin-read value; analog pins read as zero, so reset reads zero on them.
    // The value is refreshed every cycle rather than on a read strobe, so a
    // read returns a level that is at most one cycle old.
    // Pins under the comparator reference read as zero as well.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            read_q <= '0;
        end else begin
            read_q <= mux_read;
        end
    end

    // Peripheral inputs take the filtered pin level regardless of direction.
    // A peripheral may therefore watch its own drive on the pad; the parallel
    // inputs read zero while the pins are not handed to the parallel port.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pmp_in_q <= '0;
            timer_q  <= 1'b0;
        end else begin
            pmp_in_q <= pmp_active ?
                        {pin_level[PMP_LINE5_PIN], pin_level[PMP_LINE4_PIN]} : 2'h0;
            timer_q  <= timer_en && pin_level[TIMER_PIN];
        end
    end

    // Analog selection also needs the pin set as an input; keeping the
    // direction bit set is left to software, this block only reports the mode.
    assign analog_sel_o   = analog;

    // Pad drive value and drive enable.
    assign pin_out_o      = pin_out_q;
    assign pin_oe_o       = pin_oe_q;

    // Peripheral-side results.
    assign pmp_data_in_o  = pmp_in_q;
    assign timer0_clock_o = timer_q;
    assign comparator_reference_output_active_o = comparator_reference_output_en;

endmodule

// ### verif/pa_port_top_asserts.sv
// Checker for the port A pin logic: bus, analog select and pin-control relations.
// Assumes it is bound to pa_port_top and sees only that module's ports.
`timescale 1ns/1ps
module pa_port_top_asserts (
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_n_i,
    input  wire logic [pa_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [pa_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    input  wire logic [pa_pkg::DATA_W-1:0] rdata_o,
    input  wire logic [pa_pkg::PORT_W-1:0] pin_oe_o,
    input  wire logic [pa_pkg::PORT_W-1:0] analog_sel_o,
    input  wire logic                      parallel_port_pin_placement_i,
    input  wire logic                      large_package_i,
    input  wire logic [1:0]                pmp_data_in_o,
    input  wire logic                      comparator_reference_output_active_o
);
    import pa_pkg::*;
    logic       acc_q;
    logic       pmp_off;
    logic [5:0] exp_sel;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // The access bit is mirrored here because it shows at the ports only on a read of address 4.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            acc_q <= 1'b0;
        end else if (wr_i && addr_i == OFS_WDT_CTRL) begin
            acc_q <= wdata_i[ACCESS_BIT];
        end
    end
    // Pin modes a shared-space write should give; parallel data is off on a bad strap.
    assign exp_sel = {~wdata_i[4], 1'b0, ~wdata_i[3:0]};
    assign pmp_off = parallel_port_pin_placement_i | ~large_package_i;
    property p_reset_state; $rose(rst_n_i) |-> analog_sel_o == 6'h2f && pin_oe_o == 6'h00; endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad pin state after reset");
    property p_bit4; analog_sel_o[DIGITAL_PIN] == 1'b0; endproperty
    a_bit4: assert property (p_bit4) else $error("bit 4 went analog");
    property p_latch_port;
        wr_i && addr_i == OFS_PIN_READ ##1 rd_i && addr_i == OFS_LATCH
            |=> rdata_o == ($past(wdata_i, 2) & PORT_IMPL_MASK);
    endproperty
    a_latch_port: assert property (p_latch_port) else $error("port write missed latch");
    property p_shared_wr; wr_i && addr_i == OFS_SHARED && acc_q |=> analog_sel_o == $past(exp_sel); endproperty
    a_shared_wr: assert property (p_shared_wr) else $error("analog select write wrong");
    property p_shared_lock; wr_i && addr_i == OFS_SHARED && !acc_q |=> $stable(analog_sel_o); endproperty
    a_shared_lock: assert property (p_shared_lock) else $error("analog select changed locked");
    property p_comparator_reference_output_off; comparator_reference_output_active_o && $past(comparator_reference_output_active_o) |-> !pin_oe_o[COMPARATOR_REFERENCE_OUTPUT_PIN]; endproperty
    a_comparator_reference_output_off: assert property (p_comparator_reference_output_off) else $error("bit 2 driven with reference");
    property p_pmp_off; pmp_off && $past(pmp_off) |-> pmp_data_in_o == 2'b00; endproperty
    a_pmp_off: assert property (p_pmp_off) else $error("parallel data on bad strap");
    property p_read_ana;
        rd_i && addr_i == OFS_PIN_READ && $stable(analog_sel_o)
            |=> (rdata_o[5:0] & $past(analog_sel_o)) == 6'h00;
    endproperty
    a_read_ana: assert property (p_read_ana) else $error("analog pin read nonzero");
    c_comparator_reference_output: cover property (comparator_reference_output_active_o && pin_oe_o != 6'h00);
    c_pmp: cover property (pmp_data_in_o != 2'b00);
    c_shared: cover property (wr_i && addr_i == OFS_SHARED && acc_q);
endmodule
bind pa_port_top pa_port_top_asserts u_pa_port_top_asserts (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_oe_o(pin_oe_o),
    .analog_sel_o(analog_sel_o), .parallel_port_pin_placement_i(parallel_port_pin_placement_i),
    .large_package_i(large_package_i), .pmp_data_in_o(pmp_data_in_o),
    .comparator_reference_output_active_o(comparator_reference_output_active_o));

// ### verif/tb_pa_port_top.sv
// Self-checking bench for the port A pin logic.
// Assumes the plain register port and a 10 MHz core clock.
`timescale 1ns/1ps
module tb_pa_port_top;
    import pa_pkg::*;
    typedef struct {logic [3:0] wa; logic [7:0] wd; logic [3:0] ra; logic [7:0] re;} pa_row_t;
    logic       ref_clk_i, rst_n_i, wr_i, rd_i, placement, large_pkg, pmp_oe, tmr, comparator_reference_output;
    logic [3:0] addr_i;
    logic [7:0] wdata_i, rdata_o;
    logic [5:0] pin_in_i, pin_out_o, pin_oe_o, asel;
    logic [1:0] pmp_do, pmp_di;
    int         n_errors, checks_done;
    pa_row_t    rows[7] = '{'{4'h1, 8'hff, 4'h1, 8'h3f}, '{4'h0, 8'h15, 4'h1, 8'h15},
        '{4'h2, 8'hff, 4'h2, 8'h3f}, '{4'h5, 8'ha5, 4'h5, 8'h00}, '{4'h4, 8'hff, 4'h4, 8'h10},
        '{4'h3, 8'hff, 4'h3, 8'h9f}, '{4'h4, 8'h00, 4'h3, 8'h00}};
    pa_port_top u_pa_port_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_in_i(pin_in_i),
        .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .analog_sel_o(asel),
        .parallel_port_pin_placement_i(placement), .large_package_i(large_pkg),
        .pmp_data_out_i(pmp_do), .pmp_data_oe_i(pmp_oe), .pmp_data_in_o(pmp_di),
        .timer0_clock_o(tmr), .comparator_reference_output_active_o(comparator_reference_output));
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Every bus field moves together just after an edge; idle is an all-zero cycle.
    task automatic bus(logic w, logic r, logic [3:0] a, logic [7:0] d);
        @(posedge ref_clk_i);
        wr_i <= w;
        rd_i <= r;
        addr_i <= a;
        wdata_i <= d;
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    task automatic rdc(string nm, logic [3:0] a, logic [7:0] e);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, 4'h0, 8'h00);
        #1;
        chk(nm, rdata_o, e);
    endtask
    // The analog select is only reachable with the access bit set, so open and close it.
    task automatic shared(logic [7:0] d);
        wr(OFS_WDT_CTRL, 8'h10);
        wr(OFS_SHARED, d);
        wr(OFS_WDT_CTRL, 8'h00);
    endtask
    // Eight idle cycles outlast both the pin pipeline and the input filter.
    task automatic settle();
        bus(1'b0, 1'b0, 4'h0, 8'h00);
        repeat (8) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic strap(logic [5:0] p, logic pl, logic lg, logic po, logic [1:0] pd);
        @(posedge ref_clk_i);
        pin_in_i <= p;
        placement <= pl;
        large_pkg <= lg;
        pmp_oe <= po;
        pmp_do <= pd;
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    // A hang is cut short and counted as a mismatch.
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        $display("timeout");
        n_errors++;
        print_verdict();
    end
    initial begin
        rst_n_i = 1'b0;
        bus(1'b0, 1'b0, 4'h0, 8'h00);
        strap(6'h3f, 1'b0, 1'b1, 1'b0, 2'b00);
        // The idle bus and the straps already used two of the three reset cycles.
        repeat (1) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rdc("row", rows[i].ra, rows[i].re);
        end
        $display("test table done");
        wr(OFS_DIRECTION, 8'h00);
        settle();
        chk("oe", 8'(pin_oe_o), 8'h3f);
        shared(8'h00);
        settle();
        chk("out_ana", 8'(pin_out_o), 8'h15);
        chk("asel_ana", 8'(asel), 8'h2f);
        wr(OFS_DIRECTION, 8'hff);
        settle();
        rdc("rd_ana", OFS_PIN_READ, 8'h10);
        shared(8'h1f);
        settle();
        rdc("rd_dig", OFS_PIN_READ, 8'h3f);
        $display("test direction done");
        wr(OFS_SHARED, 8'h01);
        wr(OFS_DIRECTION, 8'h00);
        settle();
        chk("cv_oe", 8'(pin_oe_o), 8'h3b);
        wr(OFS_DIRECTION, 8'hff);
        settle();
        rdc("cv_rd", OFS_PIN_READ, 8'h3b);
        chk("cv_act", 8'(comparator_reference_output), 8'h01);
        $display("test reference done");
        wr(OFS_SHARED, 8'h02);
        strap(6'h10, 1'b0, 1'b1, 1'b1, 2'b01);
        settle();
        chk("pmp_drv", 8'({pin_oe_o[5:4], pin_out_o[5:4]}), 8'h0e);
        chk("cv_off", 8'(comparator_reference_output), 8'h00);
        wr(OFS_DIRECTION, 8'h00);
        strap(6'h10, 1'b0, 1'b1, 1'b0, 2'b01);
        settle();
        chk("pmp_in", 8'({pin_oe_o[5:4], pmp_di}), 8'h02);
        strap(6'h10, 1'b1, 1'b1, 1'b1, 2'b01);
        settle();
        chk("pmp_plc", 8'({pin_oe_o[5:4], pmp_di}), 8'h0c);
        strap(6'h10, 1'b0, 1'b0, 1'b1, 2'b01);
        settle();
        chk("pmp_pkg", 8'({pin_oe_o[5:4], pmp_di}), 8'h0c);
        wr(OFS_SHARED, 8'h04);
        settle();
        chk("tmr", 8'({pin_oe_o[4], tmr}), 8'h01);
        strap(6'h00, 1'b0, 1'b0, 1'b1, 2'b01);
        settle();
        chk("tmr_lo", 8'(tmr), 8'h00);
        $display("test alternate done");
        strap(6'h3f, 1'b0, 1'b1, 1'b0, 2'b00);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk("asel_rst", 8'(asel), 8'h2f);
        chk("oe_rst", 8'(pin_oe_o), 8'h00);
        rdc("dir_rst", OFS_DIRECTION, 8'h3f);
        settle();
        rdc("pin_rst", OFS_PIN_READ, 8'h10);
        $display("test reset done");
        print_verdict();
    end
endmodule
